/* File: test/jafc_line_model.sv */
// Purpose: framer and line side that clocks bits in and out
// Assumes: link clocks stand still low between bursts
// Notes:   released data lines show the inverse of the last bit
`timescale 1ns/10ps
module jafc_line_model (
  output logic [3:0] tx_clk,
  output logic [3:0] tx_dat,
  output logic [3:0] rx_clk,
  output logic [3:0] rx_dat,
  output logic [3:0] dj_clk
);
  logic [3:0] clks [3];
  logic [3:0] dats [2];
  assign tx_clk = clks[0];
  assign rx_clk = clks[1];
  assign dj_clk = clks[2];
  assign tx_dat = dats[0];
  assign rx_dat = dats[1];
  initial begin
    clks = '{default: 4'h0};
    dats = '{default: 4'h0};
  end
  // sel 0 transmit, 1 receive, 2 dejittered read; 32 ns per bit
  task automatic burst(input int sel, input int ch, input int n, input logic [31:0] pat);
    #1.3;
    for (int i = 0; i < n; i++) begin
      if (sel < 2) dats[sel][ch] = pat[i];
      #16;
      clks[sel][ch] = 1'b1;
      #16;
      clks[sel][ch] = 1'b0;
    end
    // no keeper on the line: never leave the last bit showing
    if (sel < 2) dats[sel][ch] = ~dats[sel][ch];
  endtask
endmodule

/* File: test/jafc_monitor.sv */
// Purpose: port-level checks for the attenuator buffer control block
// Assumes: register writes land at the end of their data phase
// Notes:   keeps a shadow of mask and control bits seen on the bus
`timescale 1ns/10ps
module jafc_monitor (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA,
  input  wire logic        HREADYOUT,
  input  wire logic        HRESP,
  input  wire logic        CONTROL_SOURCE_SELECT,
  input  wire logic        ATTEN_PATH_SELECT_PIN,
  input  wire logic        ATTEN_CFG_PIN_LO,
  input  wire logic        ATTEN_CFG_PIN_HI,
  input  wire logic        INT_N
);
  logic       acc;
  logic       wp_q,   wp_d;
  logic [7:0] wo_q,   wo_d;
  logic [3:0] mask_q, mask_d;
  logic [2:0] ctrl_q [4];
  logic [2:0] ctrl_d [4];
  logic [3:0] pins;
  assign acc  = HSEL && HTRANS[jafc_pkg::HTRANS_ACT] && HREADY && CLK_EN;
  assign pins = {CONTROL_SOURCE_SELECT, ATTEN_PATH_SELECT_PIN, ATTEN_CFG_PIN_HI, ATTEN_CFG_PIN_LO};
  // a plain net, so the assertions see its value sampled at the edge
  logic rd_any;
  assign rd_any = acc && !HWRITE && HADDR[31:8] == 24'h0;
  // shadow registers take the data phase word, as the slave does
  always_comb begin
    wp_d   = wp_q;
    wo_d   = wo_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    if (CLK_EN) begin
      if (wp_q && wo_q == jafc_pkg::OFS_MASK) mask_d = HWDATA[3:0];
      if (wp_q && wo_q[7:4] == 4'h0) ctrl_d[wo_q[3:2]] = HWDATA[2:0];
      wp_d = acc && HWRITE && HADDR[31:8] == 24'h0;
      wo_d = HADDR[7:0];
    end
  end
  // registers only
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      wp_q   <= 1'b0;
      wo_q   <= 8'h00;
      mask_q <= jafc_pkg::MASK_RESET;
      ctrl_q <= '{default: jafc_pkg::CTRL_RESET};
    end else begin
      wp_q   <= wp_d;
      wo_q   <= wo_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  chk_bus_okay: assert property (CLK_EN |-> HREADYOUT && !HRESP)
    else $error("bus stalled or error response");
  chk_ctrl_read: assert property (
    acc && !HWRITE && HADDR[31:4] == 28'h0 && HADDR[3:0] % 4 == 0
    |=> HRDATA == {29'h0, $past(ctrl_q[HADDR[3:2]])}) else $error("control readback wrong");
  chk_mask_read: assert property (
    rd_any && HADDR[7:0] == jafc_pkg::OFS_MASK |=> HRDATA == {28'h0, $past(mask_q)})
    else $error("mask readback");
  chk_alarm_width: assert property (
    rd_any && HADDR[7:0] == jafc_pkg::OFS_ALARM |=> HRDATA[31:4] == 28'h0)
    else $error("alarm upper bits set");
  chk_alarm_int: assert property (rd_any && HADDR[7:0] == jafc_pkg::OFS_ALARM |=>
    $past(INT_N) == ((HRDATA[3:0] & $past(mask_q)) == 4'h0)) else $error("interrupt vs alarm");
  chk_int_masked: assert property (mask_q == 4'h0 |-> INT_N)
    else $error("interrupt while all masked");
  chk_fill_range: assert property (rd_any && HADDR[7:0] == jafc_pkg::OFS_FILL |=>
    (HRDATA & 32'hc0c0c0c0) == 32'h0 && HRDATA[5:0] <= 6'h20 && HRDATA[13:8] <= 6'h20
    && HRDATA[21:16] <= 6'h20 && HRDATA[29:24] <= 6'h20) else $error("fill out of range");
  chk_mode_pins: assert property (
    $stable(pins) [*6] ##0 (rd_any && HADDR[7:0] == jafc_pkg::OFS_MODE)
    |=> HRDATA == {28'h0, $past(pins)}) else $error("mode readback wrong");
  cov_alarm: cover property ((rd_any && HADDR[7:0] == jafc_pkg::OFS_ALARM) ##1 HRDATA[3:0] != 4'h0);
  cov_int: cover property ($fell(INT_N));
  cov_host: cover property ((rd_any && HADDR[7:0] == jafc_pkg::OFS_MODE) ##1 HRDATA[3]);
endmodule

/* File: test/testbench.sv */
// Purpose: self-checking bench for the attenuator buffer control block
// Assumes: slave holds hready low only while the clock enable is low
// Notes:   link traffic comes from the line model
`timescale 1ns/10ps
module testbench;
  logic        CLK_SYS, RESET_N, CLK_EN, HSEL, HWRITE, HRESP, HREADYOUT, INT_N;
  logic        CONTROL_SOURCE_SELECT, ATTEN_PATH_SELECT_PIN, ATTEN_CFG_PIN_LO, ATTEN_CFG_PIN_HI;
  logic [31:0] HADDR, HWDATA, HRDATA, v;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [3:0]  tx_clk, tx_dat, rx_clk, rx_dat, dj_clk, TX_DATA_OUT, RX_DATA_OUT;
  int          err_total, comparisons;
  jafc_top dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CONTROL_SOURCE_SELECT(CONTROL_SOURCE_SELECT), .ATTEN_PATH_SELECT_PIN(ATTEN_PATH_SELECT_PIN),
    .ATTEN_CFG_PIN_LO(ATTEN_CFG_PIN_LO), .ATTEN_CFG_PIN_HI(ATTEN_CFG_PIN_HI),
    .TRANSMIT_PATH_CLOCK(tx_clk), .TX_DATA_IN(tx_dat), .RECOVERED_RECEIVE_CLOCK(rx_clk),
    .RX_DATA_IN(rx_dat), .DEJITTERED_CLOCK(dj_clk), .TX_DATA_OUT(TX_DATA_OUT),
    .RX_DATA_OUT(RX_DATA_OUT), .INT_N(INT_N));
  jafc_line_model far (.tx_clk(tx_clk), .tx_dat(tx_dat), .rx_clk(rx_clk), .rx_dat(rx_dat),
    .dj_clk(dj_clk));
  // 250 MHz system clock
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  task automatic end_sim;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single word transfer; address held until hready is seen high
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge CLK_SYS);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR  <= a;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, {24'h0, a}, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] u;
    ahb(1'b1, {24'h0, a}, d, u);
  endtask
  task automatic chk_int(input logic e);
    @(posedge CLK_SYS);
    chk({31'h0, INT_N}, {31'h0, e});
  endtask
  // burst then let the synchronisers settle
  task automatic feed(input int sel, input int ch, input int n);
    far.burst(sel, ch, n, 32'h0);
    repeat (6) @(posedge CLK_SYS);
  endtask
  // a bypassed path must pass its last bit straight through
  task automatic byp(input int sel, input int ch);
    logic [3:0] o;
    for (int k = 0; k < 2; k++) begin
      far.burst(sel, ch, 2 + k, 32'h2);
      repeat (2) @(posedge CLK_SYS);
      o = sel ? RX_DATA_OUT : TX_DATA_OUT;
      chk({31'h0, o[ch]}, {31'h0, k == 0});
    end
  endtask
  initial begin
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    {CONTROL_SOURCE_SELECT, ATTEN_PATH_SELECT_PIN, ATTEN_CFG_PIN_LO, ATTEN_CFG_PIN_HI} = 4'h0;
    HSIZE = 3'h2;
    CLK_EN = 1'b1;
    RESET_N = 1'b0;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    for (int i = 0; i < 8; i++) if (i != 6) begin
      rd(8'(i * 4), v);
      chk(v, 32'h0);
    end
    ahb(1'b1, 32'h20, 32'hffffffff, v);
    ahb(1'b0, 32'h20, 32'h0, v);
    chk(v, 32'h0);
    // hardware mode: every path and depth code
    for (int m = 0; m < 8; m++) begin
      @(posedge CLK_SYS);
      ATTEN_PATH_SELECT_PIN <= m[2];
      {ATTEN_CFG_PIN_HI, ATTEN_CFG_PIN_LO} <= m[1:0];
      repeat (10) @(posedge CLK_SYS);
      rd(jafc_pkg::OFS_MODE, v);
      chk(v, {29'h0, m[2:0]});
      if (m[1:0] == 2'h1 || m[1:0] == 2'h2) begin
        rd(jafc_pkg::OFS_FILL, v);
        chk(v, {4{m[1] ? 8'h10 : 8'h08}});
        byp(m[2] ? 1 : 0, m % 4);
      end else begin
        byp(0, m % 4);
        byp(1, m % 4);
      end
    end
    // host mode, hardware pins left non-zero to show they are ignored
    @(posedge CLK_SYS);
    CONTROL_SOURCE_SELECT <= 1'b1;
    {ATTEN_PATH_SELECT_PIN, ATTEN_CFG_PIN_HI, ATTEN_CFG_PIN_LO} <= 3'h5;
    repeat (10) @(posedge CLK_SYS);
    rd(jafc_pkg::OFS_MODE, v);
    chk(v, 32'hd);
    byp(0, 2);
    byp(1, 3);
    // channel 0: short buffer on receive path, fill towards overflow
    wr(jafc_pkg::OFS_MASK, 32'h1);
    wr(jafc_pkg::OFS_CTRL0, 32'h2);
    feed(0, 0, 4);
    rd(jafc_pkg::OFS_FILL, v);
    chk(v & 32'hff, 32'h08);
    feed(1, 0, 5);
    rd(jafc_pkg::OFS_FILL, v);
    chk(v & 32'hff, 32'h0d);
    chk_int(1'b1);
    feed(1, 0, 1);
    chk_int(1'b0);
    rd(jafc_pkg::OFS_ALARM, v);
    chk(v, 32'h1);
    rd(jafc_pkg::OFS_ALARM, v);
    chk(v, 32'h0);
    rd(jafc_pkg::OFS_FILL, v);
    chk(v & 32'hff, 32'h08);
    chk_int(1'b1);
    // a marked bit behind eight stale zeros must come out ninth, in order
    far.burst(1, 0, 1, 32'h1);
    feed(2, 0, 9);
    chk({31'h0, RX_DATA_OUT[0]}, 32'h1);
    rd(jafc_pkg::OFS_ALARM, v);
    chk(v, 32'h1);
    // channel 1: long buffer on transmit path, drain towards underflow
    wr(jafc_pkg::OFS_CTRL1, 32'h5);
    rd(jafc_pkg::OFS_FILL, v);
    chk(v & 32'hff00, 32'h1000);
    feed(2, 1, 13);
    rd(jafc_pkg::OFS_ALARM, v);
    chk(v, 32'h0);
    feed(2, 1, 1);
    rd(jafc_pkg::OFS_FILL, v);
    chk(v & 32'hff00, 32'h0200);
    chk_int(1'b1);
    wr(jafc_pkg::OFS_MASK, 32'h3);
    chk_int(1'b0);
    wr(jafc_pkg::OFS_ALARM, 32'h2);
    chk_int(1'b1);
    // stalled bus: the read waits out the frozen enable and still lands
    CLK_EN <= 1'b0;
    fork
      rd(jafc_pkg::OFS_MASK, v);
      begin
        repeat (5) @(posedge CLK_SYS);
        CLK_EN <= 1'b1;
      end
    join
    chk(v, 32'h3);
    rd(jafc_pkg::OFS_ALARM, v);
    chk(v, 32'h0);
    end_sim;
  end
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
endmodule
bind jafc_top jafc_monitor mon (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .CONTROL_SOURCE_SELECT(CONTROL_SOURCE_SELECT), .ATTEN_PATH_SELECT_PIN(ATTEN_PATH_SELECT_PIN),
  .ATTEN_CFG_PIN_LO(ATTEN_CFG_PIN_LO), .ATTEN_CFG_PIN_HI(ATTEN_CFG_PIN_HI), .INT_N(INT_N));

/* File: verilog/jafc_chan.sv */
// Purpose: one channel's elastic bit buffer with limit detection
// Assumes: write and read strobes are one-cycle pulses on clk
// Notes:   recentres to half depth when disabled or reinitialised
`timescale 1ns/10ps
module jafc_chan (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       enable,
  input  wire logic       depth32,
  input  wire logic       reinit,
  input  wire logic       wr_stb,
  input  wire logic       wr_bit,
  input  wire logic       rd_stb,
  output logic            rd_bit,
  output logic            limit_hit,
  output logic [5:0]      fill
);
  logic [31:0] mem_q, mem_d;
  logic [4:0]  wr_q, wr_d, rd_q, rd_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        bit_q, bit_d;
  logic        lim_q, lim_d;
  logic [5:0]  depth;
  logic [5:0]  half;
  logic [4:0]  pmask;
  logic        do_wr, do_rd;

  // depth follows the live configuration
  assign depth = depth32 ? jafc_pkg::DEPTH_LONG : jafc_pkg::DEPTH_SHORT;
  assign half  = depth >> 1;
  assign pmask = depth32 ? jafc_pkg::PTR_MASK_L : jafc_pkg::PTR_MASK_S;

  // next state of pointers, fill and output bit
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    lim_d = 1'b0;
    do_wr = 1'b0;
    do_rd = 1'b0;
    if (!enable || reinit) begin
      // recentre so both margins start equal
      wr_d  = half[4:0];
      rd_d  = '0;
      cnt_d = half;
    end else begin
      do_wr = wr_stb && (cnt_q < depth);
      do_rd = rd_stb && (cnt_q != '0);
      if (do_wr) begin
        mem_d[wr_q] = wr_bit;
        wr_d = (wr_q + 5'h01) & pmask;
      end
      if (do_rd) begin
        bit_d = mem_q[rd_q];
        rd_d = (rd_q + 5'h01) & pmask;
      end
      cnt_d = cnt_q + {5'h00, do_wr} - {5'h00, do_rd};
      // blocked strobes at the extremes also count as limit events
      lim_d = (wr_stb || rd_stb) &&
              ((cnt_d >= depth - jafc_pkg::LIMIT_MARGIN) ||
               (cnt_d <= jafc_pkg::LIMIT_MARGIN));
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q <= '0;
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      bit_q <= 1'b0;
      lim_q <= 1'b0;
    end else if (ce) begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      lim_q <= lim_d;
    end
  end

  assign rd_bit    = bit_q;
  assign limit_hit = lim_q;
  assign fill      = cnt_q;
endmodule

/* File: verilog/jafc_pkg.sv */
// Purpose: shared constants for the jitter attenuator buffer control block
// Assumes: AHB-Lite register port, 32-bit data, four channels
// Notes:   every offset, control field position and the control and mask reset values live here
package jafc_pkg;
  localparam int          NCH          = 4;
  localparam int          PTR_W        = 5;
  localparam int          CNT_W        = 6;
  // buffer depths in bits and the alarm margin
  localparam logic [5:0]  DEPTH_SHORT  = 6'h10;
  localparam logic [5:0]  DEPTH_LONG   = 6'h20;
  localparam logic [5:0]  LIMIT_MARGIN = 6'h02;
  localparam logic [4:0]  PTR_MASK_S   = 5'h0f;
  localparam logic [4:0]  PTR_MASK_L   = 5'h1f;
  // two-bit depth configuration encodings
  localparam logic [1:0]  CFG_OFF      = 2'h0;
  localparam logic [1:0]  CFG_SHORT    = 2'h1;
  localparam logic [1:0]  CFG_LONG     = 2'h2;
  // byte offsets of the registers
  localparam logic [7:0]  OFS_CTRL0    = 8'h00;
  localparam logic [7:0]  OFS_CTRL1    = 8'h04;
  localparam logic [7:0]  OFS_CTRL2    = 8'h08;
  localparam logic [7:0]  OFS_CTRL3    = 8'h0c;
  localparam logic [7:0]  OFS_ALARM    = 8'h10;
  localparam logic [7:0]  OFS_MASK     = 8'h14;
  localparam logic [7:0]  OFS_FILL     = 8'h18;
  localparam logic [7:0]  OFS_MODE     = 8'h1c;
  // channel control fields
  localparam int          CTRL_PATH    = 0;
  localparam int          CTRL_CFG_LO  = 1;
  localparam int          CTRL_CFG_HI  = 2;
  localparam int          CTRL_W       = 3;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;
  localparam logic [3:0]  MASK_RESET   = 4'h0;
  // fill register packs one byte per channel
  localparam int          FILL_STRIDE  = 8;
  // ahb htrans bit that marks an active transfer
  localparam int          HTRANS_ACT   = 1;
endpackage

/* File: verilog/jafc_top.sv */
// Purpose: four-channel jitter attenuator buffer control with AHB-Lite registers
// Assumes: all line clocks and pins are asynchronous to CLK_SYS and much slower
// Notes:   line clocks are oversampled; edges become one-cycle strobes
// What this block does
// - Host bit picks each channel's path
// - Hardware pin picks path for all channels
// - Buffer depth is 16 or 32 bits
// - Host bits pick depth or disable per channel
// - Hardware pins pick depth or disable globally
// - Write on path clock, read on dejittered clock
// - Flag set within two bits of limits
// - Reading flag recentres buffer, clears flag
// - Host mode ignores hardware config pins
// - Limit alarm drives active-low interrupt
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module jafc_top (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        CONTROL_SOURCE_SELECT,
  input  wire logic        ATTEN_PATH_SELECT_PIN,
  input  wire logic        ATTEN_CFG_PIN_LO,
  input  wire logic        ATTEN_CFG_PIN_HI,
  input  wire logic [3:0]  TRANSMIT_PATH_CLOCK,
  input  wire logic [3:0]  TX_DATA_IN,
  input  wire logic [3:0]  RECOVERED_RECEIVE_CLOCK,
  input  wire logic [3:0]  RX_DATA_IN,
  input  wire logic [3:0]  DEJITTERED_CLOCK,
  output logic      [3:0]  TX_DATA_OUT,
  output logic      [3:0]  RX_DATA_OUT,
  output logic             INT_N
);
  localparam int NCH = jafc_pkg::NCH;

  // ---- input synchronisers ----
  // first stage feeds only the second stage
  logic [3:0] txc_s1, txc_s2, txc_s3;
  logic [3:0] txd_s1, txd_s2;
  logic [3:0] rxc_s1, rxc_s2, rxc_s3;
  logic [3:0] rxd_s1, rxd_s2;
  logic [3:0] djc_s1, djc_s2, djc_s3;
  logic [3:0] pin_s1, pin_s2;
  logic [3:0] pin_raw;

  assign pin_raw = {CONTROL_SOURCE_SELECT, ATTEN_PATH_SELECT_PIN,
                    ATTEN_CFG_PIN_HI, ATTEN_CFG_PIN_LO};

  // data is synchronised with its clock so the sampled bit lines up
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      txc_s1 <= '0;
      txc_s2 <= '0;
      txc_s3 <= '0;
      txd_s1 <= '0;
      txd_s2 <= '0;
      rxc_s1 <= '0;
      rxc_s2 <= '0;
      rxc_s3 <= '0;
      rxd_s1 <= '0;
      rxd_s2 <= '0;
      djc_s1 <= '0;
      djc_s2 <= '0;
      djc_s3 <= '0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (CLK_EN) begin
      txc_s1 <= TRANSMIT_PATH_CLOCK;
      txc_s2 <= txc_s1;
      txc_s3 <= txc_s2;
      txd_s1 <= TX_DATA_IN;
      txd_s2 <= txd_s1;
      rxc_s1 <= RECOVERED_RECEIVE_CLOCK;
      rxc_s2 <= rxc_s1;
      rxc_s3 <= rxc_s2;
      rxd_s1 <= RX_DATA_IN;
      rxd_s2 <= rxd_s1;
      djc_s1 <= DEJITTERED_CLOCK;
      djc_s2 <= djc_s1;
      djc_s3 <= djc_s2;
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // rising edges of the sampled line clocks
  logic [3:0] tx_edge, rx_edge, dj_edge;
  assign tx_edge = txc_s2 & ~txc_s3;
  assign rx_edge = rxc_s2 & ~rxc_s3;
  assign dj_edge = djc_s2 & ~djc_s3;

  logic host_mode;
  logic hw_path;
  logic [1:0] hw_cfg;
  assign host_mode = pin_s2[3];
  assign hw_path   = pin_s2[2];
  assign hw_cfg    = pin_s2[1:0];

  // ---- register state ----
  logic [2:0] ctrl_q [NCH];
  logic [2:0] ctrl_d [NCH];
  logic [3:0] alarm_q, alarm_d;
  logic [3:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wpend_q, wpend_d;
  logic [7:0]  waddr_q, waddr_d;

  // ---- effective per-channel configuration ----
  logic [3:0] path_tx;
  logic [1:0] cfg_eff [NCH];
  logic [3:0] ja_en;
  logic [3:0] ja_long;
  logic [3:0] cfg_chg;
  logic [3:0] limit_hit;
  logic [3:0] buf_bit;
  logic [5:0] fill [NCH];
  logic [3:0] read_clr;
  logic [3:0] reinit;
  logic [3:0] prev_en_q, prev_long_q, prev_path_q;

  // host bits win in host mode; pins are not looked at then
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (host_mode) begin
        path_tx[i] = ctrl_q[i][jafc_pkg::CTRL_PATH];
        cfg_eff[i] = {ctrl_q[i][jafc_pkg::CTRL_CFG_HI],
                      ctrl_q[i][jafc_pkg::CTRL_CFG_LO]};
      end else begin
        path_tx[i] = hw_path;
        cfg_eff[i] = hw_cfg;
      end
      // 11 falls back to bypass like 00
      ja_en[i]   = (cfg_eff[i] == jafc_pkg::CFG_SHORT) ||
                   (cfg_eff[i] == jafc_pkg::CFG_LONG);
      ja_long[i] = (cfg_eff[i] == jafc_pkg::CFG_LONG);
      // a depth or path change would corrupt the pointers, so recentre
      cfg_chg[i] = (ja_en[i] != prev_en_q[i]) ||
                   (ja_long[i] != prev_long_q[i]) ||
                   (path_tx[i] != prev_path_q[i]);
    end
  end

  assign reinit = cfg_chg | read_clr;

  // ---- per-channel buffers ----
  logic [3:0] wr_stb, wr_bit;
  assign wr_stb = (path_tx & tx_edge) | (~path_tx & rx_edge);
  assign wr_bit = (path_tx & txd_s2) | (~path_tx & rxd_s2);

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    jafc_chan u_chan (
      .clk       (CLK_SYS),
      .rst_n     (RESET_N),
      .ce        (CLK_EN),
      .enable    (ja_en[g]),
      .depth32   (ja_long[g]),
      .reinit    (reinit[g]),
      .wr_stb    (wr_stb[g]),
      .wr_bit    (wr_bit[g]),
      .rd_stb    (dj_edge[g]),
      .rd_bit    (buf_bit[g]),
      .limit_hit (limit_hit[g]),
      .fill      (fill[g])
    );
  end

  // ---- line outputs ----
  // bypassed paths retime on their own clock edge
  logic [3:0] txo_q, txo_d, rxo_q, rxo_d;
  always_comb begin
    txo_d = txo_q;
    rxo_d = rxo_q;
    for (int i = 0; i < NCH; i++) begin
      if (ja_en[i] && path_tx[i]) begin
        txo_d[i] = buf_bit[i];
      end else if (tx_edge[i]) begin
        txo_d[i] = txd_s2[i];
      end
      if (ja_en[i] && !path_tx[i]) begin
        rxo_d[i] = buf_bit[i];
      end else if (rx_edge[i]) begin
        rxo_d[i] = rxd_s2[i];
      end
    end
  end

  // ---- AHB-Lite slave ----
  logic       take;
  logic [7:0] aoff;
  logic       mapped;
  assign take = HSEL && HTRANS[jafc_pkg::HTRANS_ACT] && HREADY && CLK_EN;
  assign aoff = HADDR[7:0];
  assign mapped = (HADDR[31:8] == '0);

  // read data is built in the address phase and held in a flop
  always_comb begin
    rdata_d  = rdata_q;
    read_clr = '0;
    wpend_d  = take && HWRITE;
    waddr_d  = take ? aoff : waddr_q;
    if (take && !HWRITE) begin
      rdata_d = '0;
      if (!mapped) begin
        rdata_d = '0;
      end else if (aoff == jafc_pkg::OFS_CTRL0) begin
        rdata_d[2:0] = ctrl_q[0];
      end else if (aoff == jafc_pkg::OFS_CTRL1) begin
        rdata_d[2:0] = ctrl_q[1];
      end else if (aoff == jafc_pkg::OFS_CTRL2) begin
        rdata_d[2:0] = ctrl_q[2];
      end else if (aoff == jafc_pkg::OFS_CTRL3) begin
        rdata_d[2:0] = ctrl_q[3];
      end else if (aoff == jafc_pkg::OFS_ALARM) begin
        rdata_d[3:0] = alarm_q;
        read_clr     = alarm_q;
      end else if (aoff == jafc_pkg::OFS_MASK) begin
        rdata_d[3:0] = mask_q;
      end else if (aoff == jafc_pkg::OFS_FILL) begin
        for (int i = 0; i < NCH; i++) begin
          rdata_d[i*jafc_pkg::FILL_STRIDE +: 6] = fill[i];
        end
      end else if (aoff == jafc_pkg::OFS_MODE) begin
        rdata_d[3:0] = pin_s2;
      end
    end
  end

  // write data arrives one cycle after its address
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ctrl_d[i] = ctrl_q[i];
    end
    mask_d  = mask_q;
    alarm_d = alarm_q & ~read_clr;
    if (wpend_q) begin
      if (waddr_q == jafc_pkg::OFS_CTRL0) begin
        ctrl_d[0] = HWDATA[2:0];
      end else if (waddr_q == jafc_pkg::OFS_CTRL1) begin
        ctrl_d[1] = HWDATA[2:0];
      end else if (waddr_q == jafc_pkg::OFS_CTRL2) begin
        ctrl_d[2] = HWDATA[2:0];
      end else if (waddr_q == jafc_pkg::OFS_CTRL3) begin
        ctrl_d[3] = HWDATA[2:0];
      end else if (waddr_q == jafc_pkg::OFS_ALARM) begin
        alarm_d = alarm_d & ~HWDATA[3:0];
      end else if (waddr_q == jafc_pkg::OFS_MASK) begin
        mask_d = HWDATA[3:0];
      end
    end
    // a new limit event beats any clear in the same cycle
    alarm_d = alarm_d | limit_hit;
  end

  // all register and output state, frozen while CLK_EN is low
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= jafc_pkg::CTRL_RESET;
      end
      alarm_q     <= '0;
      mask_q      <= jafc_pkg::MASK_RESET;
      rdata_q     <= '0;
      wpend_q     <= 1'b0;
      waddr_q     <= '0;
      txo_q       <= '0;
      rxo_q       <= '0;
      prev_en_q   <= '0;
      prev_long_q <= '0;
      prev_path_q <= '0;
    end else if (CLK_EN) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= ctrl_d[i];
      end
      alarm_q     <= alarm_d;
      mask_q      <= mask_d;
      rdata_q     <= rdata_d;
      wpend_q     <= wpend_d;
      waddr_q     <= waddr_d;
      txo_q       <= txo_d;
      rxo_q       <= rxo_d;
      prev_en_q   <= ja_en;
      prev_long_q <= ja_long;
      prev_path_q <= path_tx;
    end
  end

  // zero wait states; stalls only while the clock enable is low
  assign HREADYOUT   = CLK_EN;
  assign HRESP       = 1'b0;
  assign HRDATA      = rdata_q;
  assign TX_DATA_OUT = txo_q;
  assign RX_DATA_OUT = rxo_q;
  // level interrupt, low while any unmasked alarm stands
  assign INT_N = ~|(alarm_q & mask_q);
endmodule
